// [include/clslc_pkg.sv]
// constants, types and the function list of the configurable logic slice
// Function
// - The slice works in exactly one of four modes: logic, ripple, RAM or ROM.
// - In logic mode each four-input table is a 16-entry truth table giving any 4-input function.
// - The two tables of a slice join through a mux on a fifth input into a five-input table.
// - Six- to eight-input functions come from cascading outputs of other slices in the group.
// - Ripple mode gives a 2-bit adder, subtractor, up counter or down counter.
// - Ripple mode also compares A and B for greater-or-equal, not-equal and less-or-equal.
// - The fast carry configuration makes carry generate and propagate for chaining slices.
// - In RAM mode each table is a 16x1 memory, and tables and slices combine into bigger ones.
// - A dual-port memory pairs a read-write slice with a companion read-only slice.
// - ROM mode reads like RAM mode but has no write port; contents come from preloading.
package clslc_pkg;

  // ****************************************
  // sizes and reset values
  // ****************************************
  localparam int CLSLC_TABLE_INPUTS = 4;
  localparam int CLSLC_TABLE_DEPTH = 16;
  localparam int CLSLC_RIPPLE_WIDTH = 2;
  localparam logic [CLSLC_TABLE_DEPTH-1:0] CLSLC_TABLE_RESET = 16'h0000;

  // ****************************************
  // modes and ripple functions
  // ****************************************
  typedef enum logic [1:0] {
    CLSLC_MODE_LOGIC = 2'h0,
    CLSLC_MODE_RIPPLE = 2'h1,
    CLSLC_MODE_RAM = 2'h3,
    CLSLC_MODE_ROM = 2'h2
  } clslc_mode_e;

  typedef enum logic [2:0] {
    CLSLC_FN_ADD = 3'h0,
    CLSLC_FN_SUB = 3'h1,
    CLSLC_FN_UP = 3'h3,
    CLSLC_FN_DOWN = 3'h2,
    CLSLC_FN_GE = 3'h6,
    CLSLC_FN_NE = 3'h7,
    CLSLC_FN_LE = 3'h5
  } clslc_fn_e;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [CLSLC_RIPPLE_WIDTH-1:0] a;
    logic [CLSLC_RIPPLE_WIDTH-1:0] b;
    logic cin;
    clslc_fn_e fn;
    logic fast_carry_config;
  } clslc_ripple_in_s;

  typedef struct packed {
    logic [CLSLC_RIPPLE_WIDTH-1:0] sum;
    logic cout;
    logic cmp;
    logic gen;
    logic prop;
  } clslc_ripple_out_s;

  typedef struct packed {
    logic we;
    logic [CLSLC_TABLE_INPUTS-1:0] waddr;
    logic [1:0] wdata;
  } clslc_write_s;

endpackage

// [logic/clslc_four_input_table.sv]
// one four-input table: preloadable 16x1 store with direct read
`timescale 1ns/1ps
module clslc_four_input_table
  import clslc_pkg::*;
#(
  parameter int DEPTH = CLSLC_TABLE_DEPTH,
  parameter int AW = CLSLC_TABLE_INPUTS
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [DEPTH-1:0] init,
  input wire logic [AW-1:0] raddr,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic wdata,
  output logic rdata,
  output logic [DEPTH-1:0] contents
);

  import clslc_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0] bits;
  } clslc_table_s;

  clslc_table_s state;
  clslc_table_s next_state;

  // ****************************************
  // store
  // ****************************************
  always_comb
  begin
    next_state = state;
    if (rst)
    begin
      next_state.bits = init;
    end
    else if (we)
    begin
      next_state.bits[waddr] = wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    state <= next_state;
  end

  // read is a plain mux of the stored bits
  assign rdata = state.bits[raddr];
  assign contents = state.bits;

endmodule

// [logic/clslc_slice.sv]
// configurable slice: two four-input tables, five-input mux, cascade, ripple and memory modes
`timescale 1ns/1ps
module clslc_slice
  import clslc_pkg::*;
#(
  parameter int DEPTH = CLSLC_TABLE_DEPTH,
  parameter int AW = CLSLC_TABLE_INPUTS,
  parameter int RW = CLSLC_RIPPLE_WIDTH
)
(
  input wire logic clk,
  input wire logic rst,
  input wire clslc_pkg::clslc_mode_e mode,
  input wire logic [DEPTH-1:0] init0,
  input wire logic [DEPTH-1:0] init1,
  input wire logic [AW-1:0] in0,
  input wire logic [AW-1:0] in1,
  input wire logic sel5,
  input wire logic cascade_sel,
  input wire logic cascade_in,
  input wire clslc_pkg::clslc_write_s wr,
  input wire logic companion_read,
  input wire logic [2*DEPTH-1:0] companion_contents,
  input wire clslc_pkg::clslc_ripple_in_s rip_in,
  output logic [1:0] table_out,
  output logic five_input_table,
  output logic cascade_out,
  output logic [2*DEPTH-1:0] shared_contents,
  output clslc_pkg::clslc_ripple_out_s rip_out
);

  import clslc_pkg::*;

  // ****************************************
  // mode decode
  // ****************************************
  logic mem_mode;
  logic write_ok;
  logic [1:0] own_rd;
  logic [1:0] comp_rd;
  logic [DEPTH-1:0] own_bits0;
  logic [DEPTH-1:0] own_bits1;
  logic [DEPTH-1:0] comp_bits0;
  logic [DEPTH-1:0] comp_bits1;

  // only one mode is ever live; ripple, write and companion paths are gated by their own decode, the table read is the default
  assign mem_mode = (mode == CLSLC_MODE_RAM) || (mode == CLSLC_MODE_ROM);
  // rom shares the ram read path but never sees a write strobe
  assign write_ok = wr.we && (mode == CLSLC_MODE_RAM);

  // ****************************************
  // the two tables
  // ****************************************
  clslc_four_input_table #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_table0 (
    .clk(clk),
    .rst(rst),
    .init(init0),
    .raddr(in0),
    .we(write_ok),
    .waddr(wr.waddr),
    .wdata(wr.wdata[0]),
    .rdata(own_rd[0]),
    .contents(own_bits0)
  );

  clslc_four_input_table #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_table1 (
    .clk(clk),
    .rst(rst),
    .init(init1),
    .raddr(in1),
    .we(write_ok),
    .waddr(wr.waddr),
    .wdata(wr.wdata[1]),
    .rdata(own_rd[1]),
    .contents(own_bits1)
  );

  // ****************************************
  // dual-port read through the companion
  // ****************************************
  assign shared_contents = {own_bits1, own_bits0};
  assign comp_bits0 = companion_contents[DEPTH-1:0];
  assign comp_bits1 = companion_contents[2*DEPTH-1:DEPTH];
  assign comp_rd[0] = comp_bits0[in0];
  assign comp_rd[1] = comp_bits1[in1];

  // ****************************************
  // table outputs, five-input mux, cascade
  // ****************************************
  always_comb
  begin
    table_out = own_rd;
    // rom reads its own preloaded tables unless the companion port is picked
    if (mem_mode && companion_read)
    begin
      // read-only port: this slice never writes what it reads here
      table_out = comp_rd;
    end
    else if (mode == CLSLC_MODE_RIPPLE)
    begin
      table_out = 2'h0;
    end
  end

  // fifth input picks a table; in memory mode this makes a 32x1 read
  assign five_input_table = sel5 ? table_out[1] : table_out[0];
  // a neighbour's output feeds in; each level of chaining adds one input
  assign cascade_out = cascade_sel ? cascade_in : five_input_table;

  // ****************************************
  // ripple arithmetic
  // ****************************************
  logic [RW:0] add_res;
  logic [RW:0] sub_res;
  logic [RW:0] up_res;
  logic [RW:0] down_res;
  logic [RW:0] res;
  logic [RW-1:0] p_bits;
  logic [RW-1:0] g_bits;
  logic ripple_on;

  assign ripple_on = (mode == CLSLC_MODE_RIPPLE);
  // subtraction uses carry-in as not-borrow so slices chain like adders
  assign add_res = {1'b0, rip_in.a} + {1'b0, rip_in.b} + {{RW{1'b0}}, rip_in.cin};
  assign sub_res = {1'b0, rip_in.a} + {1'b0, ~rip_in.b} + {{RW{1'b0}}, rip_in.cin};
  // counters step by the incoming carry so a chain counts as one
  assign up_res = {1'b0, rip_in.a} + {{RW{1'b0}}, rip_in.cin};
  assign down_res = {1'b0, rip_in.a} + {1'b0, {RW{1'b1}}} + {{RW{1'b0}}, ~rip_in.cin};

  always_comb
  begin
    res = '0;
    p_bits = '0;
    g_bits = '0;
    unique case (rip_in.fn)
      CLSLC_FN_ADD:
      begin
        res = add_res;
        p_bits = rip_in.a ^ rip_in.b;
        g_bits = rip_in.a & rip_in.b;
      end
      CLSLC_FN_SUB:
      begin
        res = sub_res;
        p_bits = rip_in.a ^ ~rip_in.b;
        g_bits = rip_in.a & ~rip_in.b;
      end
      CLSLC_FN_UP:
      begin
        res = up_res;
        p_bits = rip_in.a;
        g_bits = '0;
      end
      CLSLC_FN_DOWN:
      begin
        res = down_res;
        p_bits = ~rip_in.a;
        g_bits = '0;
      end
      CLSLC_FN_GE, CLSLC_FN_NE, CLSLC_FN_LE:
      begin
        res = '0;
      end
      default:
      begin
        res = '0;
      end
    endcase
  end

  // ****************************************
  // operand compare
  // ****************************************
  logic cmp_res;

  // compare codes never drive the sum, so the flag is kept apart from the adder
  always_comb
  begin
    cmp_res = 1'b0;
    unique case (rip_in.fn)
      CLSLC_FN_GE:
      begin
        cmp_res = (rip_in.a >= rip_in.b);
      end
      CLSLC_FN_NE:
      begin
        cmp_res = (rip_in.a != rip_in.b);
      end
      CLSLC_FN_LE:
      begin
        cmp_res = (rip_in.a <= rip_in.b);
      end
      default:
      begin
        cmp_res = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    rip_out = '0;
    if (ripple_on)
    begin
      rip_out.sum = res[RW-1:0];
      rip_out.cout = res[RW];
      rip_out.cmp = cmp_res;
      if (rip_in.fast_carry_config)
      begin
        // slice-level terms let a lookahead stage skip the ripple
        rip_out.gen = g_bits[1] | (p_bits[1] & g_bits[0]);
        rip_out.prop = &p_bits;
      end
    end
  end

endmodule

// [test/clslc_slice_checker.sv]
// port checker for the configurable logic slice
`timescale 1ns/1ps
module clslc_slice_checker
  import clslc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire clslc_pkg::clslc_mode_e mode,
  input wire logic [3:0] in0,
  input wire logic [3:0] in1,
  input wire logic sel5,
  input wire logic cascade_sel,
  input wire logic cascade_in,
  input wire clslc_pkg::clslc_write_s wr,
  input wire logic companion_read,
  input wire logic [31:0] companion_contents,
  input wire clslc_pkg::clslc_ripple_in_s rip_in,
  input wire logic [1:0] table_out,
  input wire logic five_input_table,
  input wire logic cascade_out,
  input wire logic [31:0] shared_contents,
  input wire clslc_pkg::clslc_ripple_out_s rip_out
);
  import clslc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_write;
    mode == CLSLC_MODE_RAM && wr.we;
  endsequence
  a_ram_write: assert property (s_write |=>
    {shared_contents[16 + $past(wr.waddr)], shared_contents[$past(wr.waddr)]} == $past(wr.wdata))
    else $error("write lost");
  a_store_hold: assert property (!(mode == CLSLC_MODE_RAM && wr.we) |=>
    $stable(shared_contents)) else $error("store changed");
  a_logic_read: assert property (mode == CLSLC_MODE_LOGIC |->
    table_out == {shared_contents[16 + in1], shared_contents[in0]}) else $error("table read");
  a_five_mux: assert property (mode == CLSLC_MODE_LOGIC |->
    five_input_table == table_out[sel5]) else $error("five mux");
  a_cascade_pick: assert property (
    cascade_out == (cascade_sel ? cascade_in : five_input_table)) else $error("cascade");
  a_ripple_idle: assert property (mode != CLSLC_MODE_RIPPLE |->
    rip_out == '0) else $error("ripple idle");
  a_ripple_add: assert property (mode == CLSLC_MODE_RIPPLE && rip_in.fn == CLSLC_FN_ADD |->
    {rip_out.cout, rip_out.sum} == rip_in.a + rip_in.b + rip_in.cin) else $error("add");
  a_companion_read: assert property (mode == CLSLC_MODE_RAM && companion_read |->
    table_out == {companion_contents[16 + in1], companion_contents[in0]}) else $error("companion");
endmodule

// [test/clslc_companion.sv]
// companion slice model: preloaded store seen through the read-only port
`timescale 1ns/1ps
module clslc_companion
#(
  parameter logic [31:0] PRELOAD = 32'h5A3CC3A5
)
(
  input wire logic [4:0] addr,
  output logic [31:0] contents,
  output logic cascade_out
);
  assign contents = PRELOAD;
  assign cascade_out = PRELOAD[addr];
endmodule

// [test/clslc_slice_tb.sv]
// self-checking bench for the configurable logic slice
`timescale 1ns/1ps
module clslc_slice_tb;
  import clslc_pkg::*;
  logic clk, rst, sel5, cascade_sel, cascade_in, companion_read, five_input_table, cascade_out;
  clslc_mode_e mode;
  logic [15:0] init0, init1;
  logic [3:0] in0, in1;
  logic [1:0] table_out;
  logic [31:0] companion_contents, shared_contents;
  clslc_write_s wr;
  clslc_ripple_in_s rip_in;
  clslc_ripple_out_s rip_out;
  int failures, checks_done;
  clslc_slice uut (
    .clk(clk),
    .rst(rst),
    .mode(mode),
    .init0(init0),
    .init1(init1),
    .in0(in0),
    .in1(in1),
    .sel5(sel5),
    .cascade_sel(cascade_sel),
    .cascade_in(cascade_in),
    .wr(wr),
    .companion_read(companion_read),
    .companion_contents(companion_contents),
    .rip_in(rip_in),
    .table_out(table_out),
    .five_input_table(five_input_table),
    .cascade_out(cascade_out),
    .shared_contents(shared_contents),
    .rip_out(rip_out)
  );
  clslc_companion partner (.addr({sel5, in1}), .contents(companion_contents),
    .cascade_out(cascade_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_logic;
    logic f;
    for (int i = 0; i < 64; i++)
    begin
      @(negedge clk);
      {cascade_sel, sel5, in0} = i[5:0];
      in1 = in0;
      f = sel5 ? init1[in0] : init0[in0];
      #1;
      chk(table_out, {init1[in1], init0[in0]});
      chk(five_input_table, f);
      chk(cascade_out, cascade_sel ? cascade_in : f);
    end
    $display("test logic done");
  endtask
  task automatic t_ripple;
    logic [2:0] s;
    logic [1:0] o, p, g;
    logic k, c, ar;
    mode = CLSLC_MODE_RIPPLE;
    for (int v = 0; v < 512; v++)
    begin
      @(negedge clk);
      rip_in = v[8:0];
      case (rip_in.fn)
        CLSLC_FN_ADD: o = rip_in.b;
        CLSLC_FN_SUB: o = ~rip_in.b;
        CLSLC_FN_DOWN: o = 2'h3;
        default: o = 2'h0;
      endcase
      k = (rip_in.fn == CLSLC_FN_DOWN) ? !rip_in.cin : rip_in.cin;
      ar = rip_in.fn inside {CLSLC_FN_ADD, CLSLC_FN_SUB, CLSLC_FN_UP, CLSLC_FN_DOWN};
      s = ar ? rip_in.a + o + k : 3'h0;
      p = ar ? rip_in.a ^ o : 2'h0;
      g = (ar && rip_in.fn != CLSLC_FN_DOWN) ? rip_in.a & o : 2'h0;
      case (rip_in.fn)
        CLSLC_FN_GE: c = rip_in.a >= rip_in.b;
        CLSLC_FN_NE: c = rip_in.a != rip_in.b;
        CLSLC_FN_LE: c = rip_in.a <= rip_in.b;
        default: c = 1'h0;
      endcase
      #1;
      chk(rip_out, {s[1:0], s[2], c, rip_in.fast_carry_config & (g[1] | p[1] & g[0]),
        rip_in.fast_carry_config & (&p)});
    end
    $display("test ripple done");
  endtask
  task automatic t_ram;
    logic [31:0] exp;
    exp = {init1, init0};
    mode = CLSLC_MODE_RAM;
    for (int i = 0; i < 17; i++)
    begin
      @(negedge clk);
      chk(shared_contents, exp);
      chk(table_out, {exp[16 + in1], exp[in0]});
      wr = {i < 16, i[3:0], i[2:1]};
      in0 = i[3:0];
      in1 = i[3:0];
      if (i < 16)
        {exp[16 + i], exp[i]} = i[2:1];
    end
    companion_read = 1'h1;
    for (int i = 0; i < 16; i++)
    begin
      @(negedge clk);
      in0 = i[3:0];
      in1 = ~i[3:0];
      #1;
      chk(table_out, {companion_contents[16 + in1], companion_contents[in0]});
    end
    companion_read = 1'h0;
    $display("test ram done");
  endtask
  task automatic t_refuse;
    logic [31:0] keep;
    keep = shared_contents;
    for (int m = 0; m < 3; m++)
    begin
      @(negedge clk);
      mode = clslc_mode_e'(m);
      wr = {1'h1, 4'h3, 2'h2};
      @(negedge clk);
      chk(shared_contents, keep);
    end
    // rom mode with the write strobe still high: 32x1 read of the bits kept from the ram test
    for (int i = 0; i < 32; i++)
    begin
      @(negedge clk);
      {sel5, in0} = i[4:0];
      in1 = in0;
      #1;
      chk(five_input_table, keep[{sel5, in0}]);
    end
    rst = 1'h1;
    @(negedge clk);
    rst = 1'h0;
    chk(shared_contents, {init1, init0});
    $display("test refuse done");
  endtask
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    rst = 1'h1;
    mode = CLSLC_MODE_LOGIC;
    init0 = 16'h6996;
    init1 = 16'h8001;
    {in0, in1, sel5, cascade_sel, companion_read} = '0;
    wr = '0;
    rip_in = '0;
    repeat (20) @(negedge clk);
    rst = 1'h0;
    t_logic;
    t_ripple;
    t_ram;
    t_refuse;
    print_verdict;
  end
endmodule
bind clslc_slice clslc_slice_checker checker_i (
  .clk(clk),
  .rst(rst),
  .mode(mode),
  .in0(in0),
  .in1(in1),
  .sel5(sel5),
  .cascade_sel(cascade_sel),
  .cascade_in(cascade_in),
  .wr(wr),
  .companion_read(companion_read),
  .companion_contents(companion_contents),
  .rip_in(rip_in),
  .table_out(table_out),
  .five_input_table(five_input_table),
  .cascade_out(cascade_out),
  .shared_contents(shared_contents),
  .rip_out(rip_out)
);
